/* File: osu_pkg.sv */
// constants and types shared by the operand shifter unit files
// assumes a single core clock; the execute stage drives all inputs
// Summary of operation
// - expand 8-bit byte shifted left anywhere
// - expand replicated byte lane constants
// - shifted immediate above 255 sets carry bit31
// - other immediate forms keep carry
// - flag illegal register shift lengths
// - rotate through carry moves one bit
// - no shift passes source through
// - zero length shift other than rotate through carry keeps carry
// - arithmetic right fills with sign bit
// - right shifts carry bit n-1
// - arithmetic right 32+ gives sign, carry
// - logical right zero fills top bits
// - logical right 32+ gives zero
// - logical right 33+ clears carry
// - left shift carries bit 32-n
// - rotate right carries bit n-1
// - rotate through carry inserts carry, outputs bit0
package osu_pkg;

    localparam int unsigned OSU_DATA_W     = 32;
    localparam int unsigned OSU_LEN_W      = 6;
    localparam int unsigned OSU_BYTE_W     = 8;
    localparam int unsigned OSU_ISHIFT_W   = 5;
    localparam int unsigned OSU_TYPE_W     = 3;

    localparam logic        OSU_CARRY_RST  = 1'b0;
    localparam logic [31:0] OSU_BYTE_MAX   = 32'h0000_00FF;
    localparam logic [5:0]  OSU_LEN_ZERO   = 6'h00;
    localparam logic [5:0]  OSU_LEN_ONE    = 6'h01;
    localparam logic [5:0]  OSU_LEN_RIGHT_MAX = 6'h20;
    localparam logic [5:0]  OSU_LEN_ROT_MAX   = 6'h1F;
    localparam logic [5:0]  OSU_LEN_LEFT_MAX  = 6'h1F;

    typedef enum logic [2:0] {
        OSU_SH_LSL = 3'h0,
        OSU_SH_LSR = 3'h1,
        OSU_SH_ASR = 3'h3,
        OSU_SH_ROR = 3'h2,
        OSU_SH_RRX = 3'h6
    } osu_shift_t;

    typedef enum logic [1:0] {
        OSU_IMM_SHIFTED = 2'h0,
        OSU_IMM_EVEN    = 2'h1,
        OSU_IMM_ODD     = 2'h3,
        OSU_IMM_ALL     = 2'h2
    } osu_imm_form_t;

endpackage

/* File: osu_imm_expander.sv */
// immediate constant expander for the second operand
// assumes form, byte and shift come straight from decode, same clock
module osu_imm_expander
    import osu_pkg::*;
(
    input  wire logic [1:0]  imm_form,
    input  wire logic [7:0]  imm_byte,
    input  wire logic [4:0]  imm_shift,
    output logic      [31:0] imm_value,
    output logic             imm_sets_carry
);

    wire logic [31:0] shifted_value;
    wire logic [31:0] even_value;
    wire logic [31:0] odd_value;
    wire logic [31:0] all_value;
    wire logic        is_shifted;

    // bits pushed past bit 31 are dropped: decode never encodes them
    assign shifted_value = {24'h00_0000, imm_byte} << imm_shift;
    assign even_value    = {8'h00, imm_byte, 8'h00, imm_byte};
    assign odd_value     = {imm_byte, 8'h00, imm_byte, 8'h00};
    assign all_value     = {imm_byte, imm_byte, imm_byte, imm_byte};
    assign is_shifted    = (osu_imm_form_t'(imm_form) == OSU_IMM_SHIFTED);

    assign imm_value = is_shifted ? shifted_value :
                       (osu_imm_form_t'(imm_form) == OSU_IMM_EVEN) ? even_value :
                       (osu_imm_form_t'(imm_form) == OSU_IMM_ODD)  ? odd_value  : all_value;

    // replicated forms never touch carry
    assign imm_sets_carry = is_shifted && (shifted_value > OSU_BYTE_MAX);

endmodule

/* File: osu_operand_shifter.sv */
// second operand generator: immediate expansion and barrel shifter
// assumes decode holds inputs stable for the execute cycle; carry held here
module osu_operand_shifter
    import osu_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        op_valid,
    input  wire logic        use_immediate,
    input  wire logic [1:0]  imm_form,
    input  wire logic [7:0]  imm_byte,
    input  wire logic [4:0]  imm_shift,
    input  wire logic [31:0] shift_source_register,
    input  wire logic [2:0]  shift_type,
    input  wire logic [5:0]  shift_len,
    input  wire logic        from_second_operand,
    input  wire logic        flag_update,
    input  wire logic        carry_load,
    input  wire logic        carry_load_value,
    output logic      [31:0] flexible_second_operand,
    output logic             shift_carry_out,
    output logic             carry_changes,
    output logic             shift_len_legal,
    output logic             carry_flag
);

    ////////////////////////////////////////////////////////////////////////
    // carry flag storage

    logic carry_q;
    logic carry_d;

    ////////////////////////////////////////////////////////////////////////
    // shift functions, each returns {carry, result}

    function automatic logic [32:0] osu_lsl(input logic [31:0] src, input logic [5:0] n);
        logic [63:0] wide;
        wide = {32'h0000_0000, src} << n;
        return {wide[32], wide[31:0]};
    endfunction

    function automatic logic [32:0] osu_lsr(input logic [31:0] src, input logic [5:0] n);
        logic [63:0] wide;
        wide = {src, 32'h0000_0000} >> n;
        // n of 33 up pulls a zero into bit 31
        return {wide[31], wide[63:32]};
    endfunction

    function automatic logic [32:0] osu_asr(input logic [31:0] src, input logic [5:0] n);
        logic [63:0] wide;
        wide = $signed({src, 32'h0000_0000}) >>> n;
        // sign extension keeps bit 31 for any length of 32 up
        return {wide[31], wide[63:32]};
    endfunction

    function automatic logic [32:0] osu_ror(input logic [31:0] src, input logic [5:0] n);
        logic [63:0] wide;
        wide = {src, src} >> n[4:0];
        // lengths above 32 wrap; 32 itself leaves src, carry bit 31
        return {wide[31], wide[31:0]};
    endfunction

    function automatic logic [32:0] osu_rrx(input logic [31:0] src, input logic cin);
        return {src[0], cin, src[31:1]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // immediate path

    wire logic [31:0] imm_value;
    wire logic        imm_sets_carry;

    osu_imm_expander u_imm (
        .imm_form       (imm_form),
        .imm_byte       (imm_byte),
        .imm_shift      (imm_shift),
        .imm_value      (imm_value),
        .imm_sets_carry (imm_sets_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // register shift path, purely combinational

    wire osu_shift_t  sh_kind;
    wire logic        len_zero;
    wire logic [32:0] lsl_res;
    wire logic [32:0] lsr_res;
    wire logic [32:0] asr_res;
    wire logic [32:0] ror_res;
    wire logic [32:0] rrx_res;
    wire logic [32:0] sel_res;
    wire logic        reg_carry_valid;
    wire logic        right_len_ok;
    wire logic        left_len_ok;
    wire logic        rot_len_ok;

    assign sh_kind  = osu_shift_t'(shift_type);
    assign len_zero = (shift_len == OSU_LEN_ZERO);

    // source only read, never written back
    assign lsl_res = osu_lsl(shift_source_register, shift_len);
    assign lsr_res = osu_lsr(shift_source_register, shift_len);
    assign asr_res = osu_asr(shift_source_register, shift_len);
    assign ror_res = osu_ror(shift_source_register, shift_len);
    assign rrx_res = osu_rrx(shift_source_register, carry_q);

    // zero length on any but rrx means no shift at all
    assign sel_res = (sh_kind == OSU_SH_RRX) ? rrx_res :
                     len_zero                ? {carry_q, shift_source_register} :
                     (sh_kind == OSU_SH_LSR) ? lsr_res :
                     (sh_kind == OSU_SH_ASR) ? asr_res :
                     (sh_kind == OSU_SH_ROR) ? ror_res : lsl_res;

    assign reg_carry_valid = (sh_kind == OSU_SH_RRX) || !len_zero;

    // second operand forms limit lengths; direct shifts take any length
    assign right_len_ok = (shift_len >= OSU_LEN_ONE) && (shift_len <= OSU_LEN_RIGHT_MAX);
    assign left_len_ok  = (shift_len <= OSU_LEN_LEFT_MAX);
    assign rot_len_ok   = (shift_len >= OSU_LEN_ONE) && (shift_len <= OSU_LEN_ROT_MAX);

    assign shift_len_legal = use_immediate || !from_second_operand ||
                             ((sh_kind == OSU_SH_LSR || sh_kind == OSU_SH_ASR) ? right_len_ok :
                              (sh_kind == OSU_SH_LSL) ? left_len_ok :
                              (sh_kind == OSU_SH_ROR) ? rot_len_ok :
                              (sh_kind == OSU_SH_RRX) ? len_zero : 1'b0);

    ////////////////////////////////////////////////////////////////////////
    // operand and carry select

    wire logic carry_src_valid;

    assign flexible_second_operand = use_immediate ? imm_value : sel_res[31:0];
    assign carry_src_valid = use_immediate ? imm_sets_carry : reg_carry_valid;
    assign carry_changes   = flag_update && carry_src_valid;
    assign shift_carry_out = !carry_changes   ? carry_q :
                             use_immediate    ? imm_value[31] : sel_res[32];

    // an illegal length is discarded rather than half applied
    always_comb begin
        carry_d = carry_q;
        if (carry_load) begin
            carry_d = carry_load_value;
        end else if (op_valid && carry_changes && shift_len_legal) begin
            carry_d = shift_carry_out;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            carry_q <= OSU_CARRY_RST;
        end else begin
            carry_q <= carry_d;
        end
    end

    assign carry_flag = carry_q;

endmodule

/* File: osu_shifter_monitor.sv */
// port checker for the operand shifter unit
// bound to every osu_operand_shifter instance
module osu_shifter_monitor
    import osu_pkg::*;
(
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        op_valid,
    input wire logic        use_immediate,
    input wire logic [1:0]  imm_form,
    input wire logic [31:0] shift_source_register,
    input wire logic [2:0]  shift_type,
    input wire logic [5:0]  shift_len,
    input wire logic        from_second_operand,
    input wire logic        flag_update,
    input wire logic        carry_load,
    input wire logic [31:0] flexible_second_operand,
    input wire logic        shift_carry_out,
    input wire logic        carry_changes,
    input wire logic        shift_len_legal,
    input wire logic        carry_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic rg = !use_immediate;
    wire logic wr = op_valid && carry_changes && shift_len_legal;
    ////////////////////////////////////////////////////////////
    a_len_zero_keep: assert property (rg && shift_type != 3'h6 && shift_len == 6'h00
        |-> !carry_changes && shift_carry_out == carry_flag) else $error("zero length changed carry");
    a_rrx_extend: assert property (rg && shift_type == 3'h6 |->
        flexible_second_operand == {carry_flag, shift_source_register[31:1]}) else $error("rrx result wrong");
    a_lsr_long_zero: assert property (rg && shift_type == 3'h1 && shift_len >= 6'h21 && flag_update
        |-> flexible_second_operand == 32'h0 && !shift_carry_out) else $error("long lsr not zero");
    a_asr_long_sign: assert property (rg && shift_type == 3'h3 && shift_len >= 6'h20
        |-> flexible_second_operand == {32{shift_source_register[31]}}) else $error("long asr not sign");
    a_pass_through: assert property (rg && shift_type == 3'h0 && shift_len == 6'h00
        |-> flexible_second_operand == shift_source_register) else $error("no shift altered value");
    a_imm_big_carry: assert property (use_immediate && imm_form == 2'h0 && flag_update
        && flexible_second_operand > 32'h0000_00FF |-> carry_changes
        && shift_carry_out == flexible_second_operand[31]) else $error("immediate carry wrong");
    a_imm_rep_keep: assert property (use_immediate && imm_form != 2'h0 |-> !carry_changes)
        else $error("replicated immediate changed carry");
    a_rot_len_legal: assert property (from_second_operand && rg && shift_type == 3'h2
        && shift_len >= 6'h20 |-> !shift_len_legal) else $error("long rotate accepted");
    a_carry_write: assert property (wr && !carry_load |=> carry_flag == $past(shift_carry_out))
        else $error("carry not written");
    a_carry_hold: assert property (!wr && !carry_load |=> $stable(carry_flag))
        else $error("carry changed unasked");
endmodule
bind osu_operand_shifter osu_shifter_monitor mon_u (.*);

/* File: osu_decode_model.sv */
// decode stage stand-in: validity and flag-setting request
// assumes the bench picks bubbles and flag-setting instructions
module osu_decode_model (
    input  wire logic srst,
    input  wire logic bubble,
    input  wire logic want_flags,
    output logic      op_valid,
    output logic      flag_update
);
    // branch targets handed on by decode keep pc bit0 set; not modelled here
    // no valid instruction while the core is held in reset
    assign op_valid    = !srst && !bubble;
    assign flag_update = want_flags;
endmodule

/* File: operand_shifter_unit_test.sv */
// self-checking bench for the operand shifter unit
// assumes one 10 MHz clock; decode model supplies valid and flag request
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module operand_shifter_unit_test
    import osu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, srst = 1, ui = 0, fso = 0, fw = 0, bub = 0, cl = 0, clv = 0, cf = 0;
    logic [1:0]  fm = 0;
    logic [7:0]  ib = 0;
    logic [4:0]  ish = 0;
    logic [31:0] src = 0, op, ev, r;
    logic [2:0]  st = 0;
    logic [5:0]  sl = 0;
    logic        ov, fl, co, chg, lg, cfl, ec, eg, ecar;
    logic [32:0] e;
    int          fails = 0, total_checks = 0, cyc = 0, seed = 32'h41ec_7c40;
    logic [5:0]  lens [6] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h21, 6'h3F};
    logic [2:0]  types [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
    ////////////////////////////////////////////////////////////
    function automatic logic [32:0] sh(logic [31:0] s, logic [2:0] t, logic [5:0] n, logic c);
        int m = n % 32;
        if (t == 3'h6) return {s[0], c, s[31:1]};
        if (n == 0) return {c, s};
        case (t)
            3'h1: return n < 32 ? {s[n-1], s >> n} : {n == 32 && s[31], 32'h0};
            3'h3: return n < 32 ? {s[n-1], $signed(s) >>> n} : {s[31], {32{s[31]}}};
            3'h2: return m == 0 ? {s[31], s} : {s[m-1], (s >> m) | (s << (32 - m))};
            default: return n < 32 ? {s[32-n], s << n} : {n == 32 && s[0], 32'h0};
        endcase
    endfunction
    function automatic logic [31:0] im(logic [1:0] f, logic [7:0] b, logic [4:0] k);
        case (f)
            2'h0: return {24'h0, b} << k;
            2'h1: return {2{8'h00, b}};
            2'h3: return {2{b, 8'h00}};
            default: return {4{b}};
        endcase
    endfunction
    function automatic logic legal(logic [2:0] t, logic [5:0] n);
        case (t)
            3'h1, 3'h3: return n >= 1 && n <= 32;
            3'h0: return n <= 31;
            3'h2: return n >= 1 && n <= 31;
            default: return n == 0;
        endcase
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    osu_decode_model dec_u (.srst(srst), .bubble(bub), .want_flags(fw), .op_valid(ov), .flag_update(fl));
    osu_operand_shifter dut_u (.clock(clock), .srst(srst), .op_valid(ov), .use_immediate(ui), .imm_form(fm),
        .imm_byte(ib), .imm_shift(ish), .shift_source_register(src), .shift_type(st), .shift_len(sl),
        .from_second_operand(fso), .flag_update(fl), .carry_load(cl), .carry_load_value(clv),
        .flexible_second_operand(op), .shift_carry_out(co), .carry_changes(chg), .shift_len_legal(lg),
        .carry_flag(cfl));
    always #50 clock = ~clock;
    always_comb begin
        e = sh(src, st, sl, cf);
        ev = ui ? im(fm, ib, ish) : e[31:0];
        ec = fl && (ui ? fm == 2'h0 && ev > 32'h0000_00FF : st == 3'h6 || sl != 0);
        eg = ui || !fso || legal(st, sl);
        ecar = ui ? ev[31] : e[32];
    end
    // bench's own carry register, then fresh random stimulus
    always @(posedge clock) begin
        if (srst) cf <= 1'b0;
        else if (cl) cf <= clv;
        else if (ov && ec && eg) cf <= ecar;
        cyc++;
        // second reset in mid-run checks recovery of the carry flag
        srst <= (cyc < 5) || (cyc >= 300 && cyc < 303);
        r = $random(seed);
        ui <= r[1:0] == 2'h0;
        st <= r[1:0] == 2'h0 ? 3'h0 : types[unsigned'($random(seed)) % 5];
        sl <= r[1:0] == 2'h0 ? 6'h01 : r[2] ? lens[unsigned'($random(seed)) % 6] : r[8:3];
        {fso, fw, bub, cl, clv} <= {r[9], r[10] | r[11], r[12] & r[13], r[16:14] == 3'h0, r[17]};
        {fm, ib, ish} <= r[31:17];
        src <= $random(seed);
        if (cyc >= 2000) begin
            fails++;
            stop_test;
        end
    end
    always @(negedge clock) begin
        `CHK(op, ev)
        `CHK(co, ec ? ecar : cf)
        `CHK(chg, ec)
        if (!ui) `CHK(lg, eg)
        `CHK(cfl, cf)
    end
    initial begin
        repeat (600) @(posedge clock);
        stop_test;
    end
endmodule
